// [verilog/bie_exec.sv]
// file: decode and execute of bit-test-skip-clear and bit-set-in-reg
// assumes: register file answers a read in the same phase (combinational rd_data)
`timescale 1ns/100ps
// What this block does
// - clear bit on test: discard next, one cycle
// - decode 01 01 as bit set
// - bit set forces one bit, others kept
// - addresses 0..127, bit indices 0..7
// - bit set leaves status flags unchanged
// - bit set: decode, read, modify, write phases
module bie_exec
#(
	parameter int INSTR_W = bie_pkg::INSTR_W,
	parameter int ADDR_W = bie_pkg::ADDR_W,
	parameter int DATA_W = bie_pkg::DATA_W
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [INSTR_W-1:0] instr,
	input wire logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] rd_addr,
	output logic rd_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic wr_en,
	output logic skip,
	output logic status_we,
	output logic [1:0] phase,
	output logic cycle_end
);
	localparam int BSEL_W = bie_pkg::BIT_HI - bie_pkg::BIT_LO + 1;

	bie_pkg::bie_phase_t ph;
	logic [INSTR_W-1:0] ir_r;
	logic flush_r;
	logic is_set;
	logic is_tst;
	logic [BSEL_W-1:0] bsel;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data_r;
	logic [DATA_W-1:0] set_mask;
	logic skip_r;
	// checker helper: clocks spent in the current flush run
	logic [2:0] flush_len_r;

	function automatic logic [3:0] opc(input logic [INSTR_W-1:0] w);
		opc = w[bie_pkg::OPC_HI:bie_pkg::OPC_LO];
	endfunction

	bie_phase_gen u_phase
	(
		.clock(clock),
		.resetn(resetn),
		.phase(ph)
	);

	// field positions are fixed by the encoding, so other widths would slice wrong bits
	if (INSTR_W != bie_pkg::OPC_HI + 1)
	begin : g_chk_instr_w
		$error("instruction word width must be 14");
	end
	if (ADDR_W != bie_pkg::ADDR_HI + 1)
	begin : g_chk_addr_w
		$error("register address width must be 7");
	end
	if (DATA_W != (1 << BSEL_W))
	begin : g_chk_data_w
		$error("data width must match the bit index range");
	end

	// one-hot set mask, one slice per data bit; only the indexed slice fires,
	// so the other bits of the register pass through the OR untouched
	for (genvar i = 0; i < DATA_W; i = i + 1)
	begin : g_set_mask
		assign set_mask[i] = (bsel == BSEL_W'(i));
	end

	// the discarded word is replaced by a no-operation cycle
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			ir_r <= bie_pkg::NOP_WORD;
		else if (ph == bie_pkg::BIE_Q4)
			ir_r <= instr;
	end

	assign is_set = (opc(ir_r) == bie_pkg::OPC_SET) && !flush_r;
	assign is_tst = (opc(ir_r) == bie_pkg::OPC_TEST_CLR) && !flush_r;
	assign bsel = ir_r[bie_pkg::BIT_HI:bie_pkg::BIT_LO];
	assign addr = ir_r[bie_pkg::ADDR_HI:0];

	// Q2 read; data held for the modify phase
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			data_r <= '0;
		else if (ph == bie_pkg::BIE_Q2 && (is_set || is_tst))
			data_r <= rd_data;
		else if (ph == bie_pkg::BIE_Q3 && is_set)
			data_r <= data_r | set_mask;
	end

	// skip decision at end of Q3; flush lasts the whole next cycle
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			skip_r <= 1'b0;
		else if (ph == bie_pkg::BIE_Q3)
			skip_r <= is_tst && !data_r[bsel];
		else if (ph == bie_pkg::BIE_Q1)
			skip_r <= 1'b0;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			flush_r <= 1'b0;
		else if (ph == bie_pkg::BIE_Q4)
			flush_r <= skip_r;
	end

	// checker helper only: counts clocks of the current flush run, cleared when it ends
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			flush_len_r <= 3'h0;
		else if (flush_r)
			flush_len_r <= flush_len_r + 3'h1;
		else
			flush_len_r <= 3'h0;
	end

	// status write enable stays low: neither instruction may touch the flags
	always_comb
	begin
		rd_addr = addr;
		rd_en = (ph == bie_pkg::BIE_Q2) && (is_set || is_tst);
		wr_addr = addr;
		wr_data = data_r;
		wr_en = (ph == bie_pkg::BIE_Q4) && is_set;
		skip = flush_r;
		status_we = 1'b0;
		phase = ph;
		cycle_end = (ph == bie_pkg::BIE_Q4);
	end

	a_set_bit_write: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |-> wr_data == ($past(rd_data, 2) | (8'h01 << bsel)))
		else $error("bit set wrote wrong data");
	a_set_phase_seq: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q2 && is_set) |-> ##2 wr_en)
		else $error("bit set did not write in Q4");
	a_skip_flush: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q3 && is_tst && !data_r[bsel]) |-> ##2 flush_r [*4])
		else $error("clear bit did not flush next cycle");
	a_no_skip_set: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q3 && is_tst && data_r[bsel]) |-> ##2 !flush_r)
		else $error("set bit caused a skip");
	a_flush_quiet: assert property (@(posedge clock) disable iff (!resetn)
		flush_r |-> !wr_en && !rd_en)
		else $error("flushed cycle touched registers");
	a_status_kept: assert property (@(posedge clock) disable iff (!resetn)
		is_set |-> !status_we)
		else $error("bit set touched status");
	a_write_addr: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |-> wr_addr == $past(rd_addr, 2))
		else $error("write address differs from read");
	a_decode_set: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |-> ir_r[13:10] == 4'h5)
		else $error("write without bit set opcode");


	// flush run: exactly one instruction cycle, started only by a failed test
	a_flush_bounded: assert property (@(posedge clock) disable iff (!resetn)
		flush_r |-> flush_len_r < 3'h4)
		else $error("flush lasted more than one cycle");
	a_flush_exact: assert property (@(posedge clock) disable iff (!resetn)
		$fell(flush_r) |-> flush_len_r == 3'h4)
		else $error("flush did not last one full cycle");
	a_flush_cause: assert property (@(posedge clock) disable iff (!resetn)
		$rose(flush_r) |->
			$past(ir_r[bie_pkg::OPC_HI:bie_pkg::OPC_LO]) == bie_pkg::OPC_TEST_CLR)
		else $error("flush without a bit test");
	a_skip_whole_cycle: assert property (@(posedge clock) disable iff (!resetn)
		$rose(skip) |-> ph == bie_pkg::BIE_Q1)
		else $error("skip did not start at a cycle boundary");
	a_test_no_write: assert property (@(posedge clock) disable iff (!resetn)
		is_tst |-> !wr_en)
		else $error("bit test wrote a register");
	a_set_never_skips: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q3 && is_set) |-> ##2 !flush_r)
		else $error("bit set caused a skip");

	// bit set datapath: selected bit one, the rest as read
	a_set_bit_one: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |-> wr_data[bsel])
		else $error("selected bit not set on write");
	a_keep_other_bits: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |-> ((wr_data ^ $past(rd_data, 2)) & ~(8'h01 << bsel)) == 8'h00)
		else $error("bit set changed another bit");

	// phase order of one instruction cycle
	a_read_after_decode: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q1 && (is_set || is_tst)) |=> rd_en)
		else $error("no read in the phase after decode");
	a_write_once: assert property (@(posedge clock) disable iff (!resetn)
		wr_en |=> !wr_en)
		else $error("more than one write in a cycle");
	a_phase_wrap: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q4) |=> (ph == bie_pkg::BIE_Q1))
		else $error("phase did not wrap after Q4");
	a_fetch_q4: assert property (@(posedge clock) disable iff (!resetn)
		(ph == bie_pkg::BIE_Q4) |=> (ir_r == $past(instr)))
		else $error("next word not taken at end of Q4");

	c_set_done: cover property (@(posedge clock) wr_en);
	c_skip_taken: cover property (@(posedge clock) $rose(flush_r));
	c_test_noskip: cover property (@(posedge clock)
		ph == bie_pkg::BIE_Q3 && is_tst && data_r[bsel]);
	c_set_top_bit: cover property (@(posedge clock) wr_en && bsel == 3'h7);
	c_set_dropped: cover property (@(posedge clock)
		flush_r && opc(ir_r) == bie_pkg::OPC_SET);
endmodule // bie_exec

// [inc/bie_pkg.sv]
// package: encodings, field positions and phase codes for the bit-instruction executor
// assumes: 14-bit instruction words, 7-bit register addresses, 8-bit data
package bie_pkg;
	localparam int INSTR_W = 14;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 10;
	localparam int BIT_HI = 9;
	localparam int BIT_LO = 7;
	localparam int ADDR_HI = 6;
	localparam logic [3:0] OPC_TEST_CLR = 4'h6;
	localparam logic [3:0] OPC_SET = 4'h5;
	localparam logic [13:0] NOP_WORD = 14'h0000;
	localparam logic [1:0] PHASE_RST = 2'h0;
	typedef enum logic [1:0] {
		BIE_Q1 = 2'b00,
		BIE_Q2 = 2'b01,
		BIE_Q3 = 2'b10,
		BIE_Q4 = 2'b11
	} bie_phase_t;
endpackage

// [verilog/bie_phase_gen.sv]
// file: four-phase generator, one phase per clock
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/100ps
module bie_phase_gen
(
	input wire logic clock,
	input wire logic resetn,
	output bie_pkg::bie_phase_t phase
);
	bie_pkg::bie_phase_t phase_r;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			phase_r <= bie_pkg::BIE_Q1;
		else
			phase_r <= bie_pkg::bie_phase_t'(phase_r + 2'h1);
	end

	assign phase = phase_r;
endmodule // bie_phase_gen

// [verif/bie_regfile_model.sv]
// model of the core register file: 128 bytes, combinational read
// assumes: write strobe and address come from bie_exec on clock
`timescale 1ns/100ps
module bie_regfile_model
(
	input wire logic clock,
	input wire logic [6:0] rd_addr,
	input wire logic rd_en,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:127];
	// unselected port shows inverted data so a late capture shows up
	assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
	always @(posedge clock)
		if (wr_en)
			mem[wr_addr] <= wr_data;
endmodule // bie_regfile_model

// [verif/bie_exec_tb.sv]
// testbench for bie_exec with a register file model
// assumes: bie_pkg compiled first
`timescale 1ns/100ps
module bie_exec_tb;
	logic clock = 0;
	logic resetn = 0;
	logic [13:0] instr = 14'h0000;
	logic [7:0] rd_data, wr_data;
	logic [6:0] rd_addr, wr_addr;
	logic rd_en, wr_en, skip, status_we, cycle_end;
	logic [1:0] phase;
	int fails = 0, n_checks = 0, n_skip = 0, n_wr = 0, n_st = 0, n_clk = 0;
	always #5 clock = ~clock;
	// tallies on the falling edge, where outputs have settled; phase restarts at Q1 on reset
	always @(negedge clock)
	begin
		if (resetn)
		begin
			n_skip += skip;
			n_wr += wr_en;
			n_st += status_we;
			check(8'(phase), 8'(n_clk % 4));
			check(8'(cycle_end), 8'(n_clk % 4 == 3));
			n_clk++;
		end
	end
	bie_exec i_bie_exec(.clock(clock), .resetn(resetn), .instr(instr), .rd_data(rd_data),
		.rd_addr(rd_addr), .rd_en(rd_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_en(wr_en), .skip(skip), .status_we(status_we), .phase(phase),
		.cycle_end(cycle_end));
	bie_regfile_model i_bie_regfile_model(.clock(clock), .rd_addr(rd_addr), .rd_en(rd_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .rd_data(rd_data));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// word is taken at the next Q4 edge
	task issue(input logic [13:0] w);
		do
		begin
			@(posedge clock);
			#1;
		end
		while (phase !== 2'h3);
		instr = w;
	endtask
	task t_set;
		i_bie_regfile_model.mem[127] = 8'h0A;
		issue(14'h17FF);
		issue(14'h0000);
		issue(14'h0000);
		check(i_bie_regfile_model.mem[127], 8'h8A);
		check(8'(n_wr), 8'h01);
	endtask
	task t_test(input logic [7:0] v, input logic [7:0] e5, input logic [7:0] es);
		i_bie_regfile_model.mem[0] = v;
		i_bie_regfile_model.mem[5] = 8'h00;
		n_skip = 0;
		issue(14'h1800);
		issue(14'h1405);
		issue(14'h0000);
		issue(14'h0000);
		check(i_bie_regfile_model.mem[5], e5);
		check(8'(n_skip), es);
	endtask
	task results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 128; i++)
			i_bie_regfile_model.mem[i] = 8'h00;
		repeat (2) @(posedge clock);
		#1 resetn = 1;
		t_set();
		t_test(8'hFE, 8'h00, 8'h04);
		t_test(8'h01, 8'h01, 8'h00);
		check(8'(n_st), 8'h00);
		results();
	end
	initial
	begin
		#2000;
		fails++;
		results();
	end
endmodule // bie_exec_tb
